// ===== verilog/duce_pkg.sv
// Behaviour
// - Every channel owns a zero register and a gain register feeding adder and multiplier.
// - Enabled, writing input, gain or zero recomputes and loads the channel's data.
// - Gain coefficient spans one half to one and a half of the input code.
// - Zero correction is signed, from -2048 to +2047 steps.
// - One shared datapath corrects one channel at a time.
// - Enabled, writing a channel's input, zero or gain register sets its busy flag.
// - The busy flag clears once the corrected code is loaded into data.
// - Each correction takes about 500 ns; queued ones run back to back.
// - Fixed priority: channel 0 first, channel 7 last; higher channels may starve.
// - While corrections remain, global busy reads one and the busy pin drives low.
// - With nothing pending, global busy clears and the busy pin is released.
// - Disabled engine keeps global busy at zero and the busy pin released.
// - Correction enable bit turns the engine on; resets to zero.
// - Disabled, a written input code goes straight into the data register.
// - Disabled, gain and zero writes only store; reads return them unchanged.
// - Channels 0 to 3 form group A, channels 4 to 7 form group B.
// - Each data register holds a 12-bit unsigned code.
// - Result is input times (gain + 2048) over 4096, plus signed zero.
// - Reset: gain 2048, zero 0, input 000h.
// - Gain is unsigned, zero is two's complement, whatever the input format.
package duce_pkg;
    localparam int CH_COUNT = 8;
    localparam int CODE_W = 12;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 7;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INPUT_BASE = 8'h20;
    localparam logic [7:0] OFS_GAIN_BASE = 8'h40;
    localparam logic [7:0] OFS_ZERO_BASE = 8'h60;
    localparam logic [7:0] OFS_DATA_BASE = 8'h80;
    localparam logic [2:0] BLK_CTRL = OFS_CONFIG[7:5];
    localparam logic [2:0] BLK_INPUT = OFS_INPUT_BASE[7:5];
    localparam logic [2:0] BLK_GAIN = OFS_GAIN_BASE[7:5];
    localparam logic [2:0] BLK_ZERO = OFS_ZERO_BASE[7:5];
    localparam logic [2:0] BLK_DATA = OFS_DATA_BASE[7:5];
    localparam logic [2:0] IDX_CONFIG = OFS_CONFIG[4:2];
    localparam logic [2:0] IDX_STATUS = OFS_STATUS[4:2];
    localparam int CFG_ENABLE_BIT = 0;
    localparam int STS_GBF_BIT = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // Reset values and arithmetic
    // ****************************************
    localparam logic [11:0] GAIN_RST = 12'h800;
    localparam logic [11:0] ZERO_RST = 12'h000;
    localparam logic [11:0] INPUT_RST = 12'h000;
    localparam logic [11:0] DATA_RST = 12'h000;
    localparam logic [12:0] GAIN_BIAS = 13'h0800;
    localparam logic [11:0] CODE_MAX = 12'hFFF;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int CORR_TIME_NS = 500;
    localparam int CORR_CYCLES = CORR_TIME_NS / CLK_PERIOD_NS;

    // Corrected code for one channel
    function automatic logic [11:0] corrected(input logic [11:0] code,
                                              input logic [11:0] gain,
                                              input logic [11:0] zero);
        logic [24:0] prod;
        logic signed [14:0] sum;
        prod = 25'(code) * 25'({1'b0, gain} + GAIN_BIAS);
        sum = $signed({2'h0, prod[24:12]}) + $signed({{3{zero[11]}}, zero});
        if (sum < 0) begin
            return 12'h000;
        end
        if (sum > $signed({3'h0, CODE_MAX})) begin
            return CODE_MAX;
        end
        return sum[11:0];
    endfunction

    // Byte-strobed update of a 12-bit field
    function automatic logic [11:0] merge(input logic [11:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        return {strb[1] ? data[11:8] : old[11:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    // Lowest set bit
    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Mapped address check
    function automatic logic mapped(input logic [2:0] blk, input logic [2:0] idx);
        return (blk == BLK_CTRL && (idx == IDX_CONFIG || idx == IDX_STATUS))
            || blk == BLK_INPUT || blk == BLK_GAIN || blk == BLK_ZERO || blk == BLK_DATA;
    endfunction
endpackage

// ===== verilog/duce_top.sv
module duce_top
    import duce_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Converter codes
    output logic [4*CODE_W-1:0] GROUP_A_CODE,
    output logic [4*CODE_W-1:0] GROUP_B_CODE,
    // Busy pin, open drain
    output logic BUSY_N_O,
    output logic BUSY_N_OE_N
);
    typedef enum logic {ST_IDLE, ST_RUN} duce_state_t;

    // ****************************************
    // State
    // ****************************************
    logic awready_reg, wready_reg, aw_got_reg, w_got_reg, bvalid_reg;
    logic arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic enable_reg, gbf_reg, oe_n_reg;
    logic [7:0] flag_reg;
    logic [11:0] input_reg [CH_COUNT];
    logic [11:0] gain_reg [CH_COUNT];
    logic [11:0] zero_reg [CH_COUNT];
    logic [11:0] data_reg [CH_COUNT];
    duce_state_t st_reg;
    logic [2:0] cur_reg;
    logic [CNT_W-1:0] cnt_reg;

    // ****************************************
    // Decode
    // ****************************************
    logic wr_en, wr_chan, wr_cfg, done, enable_next;
    logic [2:0] wr_blk, wr_idx, rd_blk, rd_idx, pick_ch;
    logic [7:0] set_vec, clr_vec, flag_next;
    logic [11:0] corr_val;
    logic [31:0] rd_word;

    assign wr_en = aw_got_reg & w_got_reg & ~bvalid_reg;
    assign wr_blk = awaddr_reg[7:5];
    assign wr_idx = awaddr_reg[4:2];
    assign rd_blk = S_AXI_ARADDR[7:5];
    assign rd_idx = S_AXI_ARADDR[4:2];
    assign wr_cfg = wr_en && wr_blk == BLK_CTRL && wr_idx == IDX_CONFIG;
    assign wr_chan = wr_en && (wr_blk == BLK_INPUT || wr_blk == BLK_GAIN || wr_blk == BLK_ZERO);
    assign enable_next = (wr_cfg && wstrb_reg[0]) ? wdata_reg[CFG_ENABLE_BIT] : enable_reg;
    assign set_vec = (wr_chan && enable_reg) ? (8'h01 << wr_idx) : 8'h00;
    assign clr_vec = done ? (8'h01 << cur_reg) : 8'h00;
    assign flag_next = enable_next ? ((flag_reg & ~clr_vec) | set_vec) : 8'h00;
    assign pick_ch = first_set(flag_reg);
    assign done = st_reg == ST_RUN && cnt_reg == '0 && enable_reg;
    assign corr_val = corrected(input_reg[cur_reg], gain_reg[cur_reg], zero_reg[cur_reg]);
    assign rd_word = (rd_blk == BLK_CTRL && rd_idx == IDX_CONFIG) ?
                         (32'(enable_reg) << CFG_ENABLE_BIT) :
                     (rd_blk == BLK_CTRL && rd_idx == IDX_STATUS) ?
                         ((32'(gbf_reg) << STS_GBF_BIT) | 32'(flag_reg)) :
                     rd_blk == BLK_INPUT ? 32'(input_reg[rd_idx]) :
                     rd_blk == BLK_GAIN ? 32'(gain_reg[rd_idx]) :
                     rd_blk == BLK_ZERO ? 32'(zero_reg[rd_idx]) :
                     rd_blk == BLK_DATA ? 32'(data_reg[rd_idx]) : 32'h0;

    // ****************************************
    // Outputs
    // ****************************************
    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign GROUP_A_CODE = {data_reg[3], data_reg[2], data_reg[1], data_reg[0]};
    assign GROUP_B_CODE = {data_reg[7], data_reg[6], data_reg[5], data_reg[4]};
    assign BUSY_N_O = 1'b0;
    assign BUSY_N_OE_N = oe_n_reg;

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && awready_reg) begin
                awaddr_reg <= S_AXI_AWADDR;
                aw_got_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (S_AXI_WVALID && wready_reg) begin
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
                w_got_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (wr_en) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= mapped(wr_blk, wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_reg && S_AXI_BREADY) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else begin
            if (S_AXI_ARVALID && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= mapped(rd_blk, rd_idx) ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid_reg && S_AXI_RREADY) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Channel registers and flags
    // ****************************************
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            enable_reg <= 1'b0;
            flag_reg <= 8'h00;
            gbf_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            for (int i = 0; i < CH_COUNT; i++) begin
                input_reg[i] <= INPUT_RST;
                gain_reg[i] <= GAIN_RST;
                zero_reg[i] <= ZERO_RST;
                data_reg[i] <= DATA_RST;
            end
        end else begin
            enable_reg <= enable_next;
            flag_reg <= flag_next;
            gbf_reg <= |flag_next;
            oe_n_reg <= ~|flag_next;
            if (wr_en && wr_blk == BLK_INPUT) begin
                input_reg[wr_idx] <= merge(input_reg[wr_idx], wdata_reg, wstrb_reg);
            end
            if (wr_en && wr_blk == BLK_GAIN) begin
                gain_reg[wr_idx] <= merge(gain_reg[wr_idx], wdata_reg, wstrb_reg);
            end
            if (wr_en && wr_blk == BLK_ZERO) begin
                zero_reg[wr_idx] <= merge(zero_reg[wr_idx], wdata_reg, wstrb_reg);
            end
            if (wr_en && wr_blk == BLK_INPUT && !enable_reg) begin
                data_reg[wr_idx] <= merge(input_reg[wr_idx], wdata_reg, wstrb_reg);
            end
            if (done) begin
                data_reg[cur_reg] <= corr_val;
            end
        end
    end

    // ****************************************
    // Correction sequencer
    // ****************************************
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st_reg <= ST_IDLE;
            cur_reg <= 3'h0;
            cnt_reg <= '0;
        end else begin
            unique case (st_reg)
                ST_IDLE: begin
                    if (enable_reg && flag_reg != 8'h00) begin
                        st_reg <= ST_RUN;
                        cur_reg <= pick_ch;
                        cnt_reg <= CNT_W'(CORR_CYCLES - 1);
                    end
                end
                ST_RUN: begin
                    if (!enable_reg || cnt_reg == '0) begin
                        st_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    property p_flag_set;
        (set_vec != 8'h00) |=> ((flag_reg & $past(set_vec)) == $past(set_vec));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("busy flag not set");

    property p_flag_clear;
        (done && !set_vec[cur_reg] && !wr_cfg) |=> !flag_reg[$past(cur_reg)];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("busy flag not cleared");

    property p_result;
        done |=> data_reg[$past(cur_reg)] == $past(corr_val);
    endproperty
    a_result: assert property (p_result) else $error("corrected code not loaded");

    property p_duration;
        (st_reg == ST_IDLE && enable_reg && flag_reg != 8'h00) |=>
            (st_reg == ST_RUN && enable_reg) [*4] ##121 (done || !enable_reg);
    endproperty
    a_duration: assert property (p_duration) else $error("correction time wrong");

    property p_priority;
        (st_reg == ST_IDLE && enable_reg && flag_reg != 8'h00) |=>
            (($past(flag_reg) >> cur_reg) & 8'h01) == 8'h01 &&
            (($past(flag_reg) & ((8'h01 << cur_reg) - 8'h01)) == 8'h00);
    endproperty
    a_priority: assert property (p_priority) else $error("wrong channel served");

    property p_busy_drive;
        (flag_next != 8'h00) |=> gbf_reg && !BUSY_N_OE_N;
    endproperty
    a_busy_drive: assert property (p_busy_drive) else $error("busy not shown");

    property p_busy_release;
        (flag_next == 8'h00) |=> !gbf_reg && BUSY_N_OE_N;
    endproperty
    a_busy_release: assert property (p_busy_release) else $error("busy not released");

    property p_disabled_idle;
        !enable_reg |-> !gbf_reg && BUSY_N_OE_N && flag_reg == 8'h00;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("busy while disabled");

    property p_bypass;
        (wr_en && wr_blk == BLK_INPUT && !enable_reg && wstrb_reg[1:0] == 2'h3) |=>
            data_reg[$past(wr_idx)] == $past(wdata_reg[11:0]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass copy missing");

    property p_no_math_off;
        (!enable_reg && !enable_next) |=> st_reg == ST_IDLE && flag_reg == 8'h00;
    endproperty
    a_no_math_off: assert property (p_no_math_off) else $error("engine ran while off");

    c_correction: cover property (done);
    c_queue: cover property ($countones(flag_reg) >= 2 ##1 done);
    c_bypass: cover property (wr_en && wr_blk == BLK_INPUT && !enable_reg);
    c_saturate: cover property (done && corr_val == CODE_MAX);
endmodule

// ===== verification/duce_host.sv
module duce_host (
    // Clock
    input wire logic clk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Idle bus
    // ****************************************
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // ****************************************
    // Register cycles
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule

// ===== verification/tb_top.sv
`define CHK(nm, ex, got) \
    begin \
        n_compared++; \
        if ((got) !== (ex)) begin \
            $display("[ERR] %s expected %h seen %h", nm, ex, got); \
            fails++; \
        end \
    end

module tb_top
    import duce_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rst = 1'b1;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd_val;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [47:0] code_a, code_b;
    logic busy_o, busy_oe_n;
    wire busy_pin;
    wire [95:0] codes;
    int fails = 0;
    int n_compared = 0;
    logic [11:0] cc [5] = '{12'h800, 12'h800, 12'hFFF, 12'h010, 12'hABC};
    logic [11:0] cg [5] = '{12'h000, 12'hFFF, 12'hFFF, 12'h800, 12'h800};
    logic [11:0] cz [5] = '{12'h000, 12'h000, 12'h7FF, 12'h800, 12'h005};

    // Pull-up on the open-drain busy line
    assign busy_pin = busy_oe_n ? 1'b1 : busy_o;
    assign codes = {code_b, code_a};

    duce_host u_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    duce_top u_dut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .GROUP_A_CODE(code_a), .GROUP_B_CODE(code_b), .BUSY_N_O(busy_o),
        .BUSY_N_OE_N(busy_oe_n));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] ra(input logic [7:0] base, input int ch);
        return base + 8'(4 * ch);
    endfunction

    function automatic logic [11:0] exp_code(input logic [11:0] c, input logic [11:0] g,
                                             input logic [11:0] z);
        int s;
        s = ((int'(c) * (int'(g) + 2048)) >>> 12) + int'($signed(z));
        return (s < 0) ? 12'h000 : (s > 4095) ? 12'hFFF : 12'(s);
    endfunction

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        u_host.wr(a, d, resp);
        `CHK("write resp", RESP_OKAY, resp)
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
        u_host.rd(a, rd_val, resp);
        `CHK(nm, ex, rd_val)
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        while (busy_pin === 1'b0) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic stop_test();
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_values();
        for (int ch = 0; ch < 8; ch++) begin
            rchk(ra(OFS_GAIN_BASE, ch), 32'h00000800, "gain reset");
            rchk(ra(OFS_ZERO_BASE, ch), 32'h0, "zero reset");
            rchk(ra(OFS_INPUT_BASE, ch), 32'h0, "input reset");
        end
        u_host.wr(8'h08, 32'h1, resp);
        `CHK("unmapped wr resp", RESP_SLVERR, resp)
        rchk(OFS_CONFIG, 32'h0, "enable reset");
        rchk(OFS_STATUS, 32'h0, "status reset");
        u_host.rd(8'h08, rd_val, resp);
        `CHK("unmapped resp", RESP_SLVERR, resp)
        `CHK("unmapped data", 32'h0, rd_val)
    endtask

    task automatic t_disabled();
        w(ra(OFS_INPUT_BASE, 5), 32'h00000ABC);
        `CHK("direct copy", 12'hABC, codes[60 +: 12])
        `CHK("busy pin off", 1'b1, busy_pin)
        rchk(OFS_STATUS, 32'h0, "status off");
        w(ra(OFS_GAIN_BASE, 5), 32'h00000123);
        w(ra(OFS_ZERO_BASE, 5), 32'h00000FFF);
        rchk(ra(OFS_GAIN_BASE, 5), 32'h00000123, "gain store");
        rchk(ra(OFS_ZERO_BASE, 5), 32'h00000FFF, "zero store");
        `CHK("no recompute", 12'hABC, codes[60 +: 12])
    endtask

    task automatic t_corr();
        int n;
        for (int i = 0; i < 5; i++) begin
            w(OFS_CONFIG, 32'h0);
            w(ra(OFS_GAIN_BASE, i), {20'h0, cg[i]});
            w(ra(OFS_ZERO_BASE, i), {20'h0, cz[i]});
            w(OFS_CONFIG, 32'h1);
            w(ra(OFS_INPUT_BASE, i), {20'h0, cc[i]});
            `CHK("busy pin low", 1'b0, busy_pin)
            u_host.rd(OFS_STATUS, rd_val, resp);
            `CHK("flags set", 2'b11, {rd_val[STS_GBF_BIT], rd_val[i]})
            wait_idle(n);
            `CHK("corr time", 1'b1, (n > 100 && n < 140))
            `CHK("corrected", exp_code(cc[i], cg[i], cz[i]), codes[i*12 +: 12])
            rchk(OFS_STATUS, 32'h0, "flags clear");
            rchk(ra(OFS_DATA_BASE, i), {20'h0, exp_code(cc[i], cg[i], cz[i])}, "data reg");
        end
    endtask

    task automatic t_prio();
        int n;
        w(ra(OFS_INPUT_BASE, 7), 32'h00000100);
        w(ra(OFS_INPUT_BASE, 2), 32'h00000200);
        w(ra(OFS_INPUT_BASE, 1), 32'h00000300);
        rd_val = 32'h2;
        while (rd_val[1] !== 1'b0) begin
            u_host.rd(OFS_STATUS, rd_val, resp);
        end
        `CHK("order", 2'b10, {rd_val[2], rd_val[7]})
        wait_idle(n);
        `CHK("ch1", exp_code(12'h300, cg[1], cz[1]), codes[12 +: 12])
        `CHK("ch2", exp_code(12'h200, cg[2], cz[2]), codes[24 +: 12])
        `CHK("ch7", exp_code(12'h100, GAIN_RST, ZERO_RST), codes[84 +: 12])
    endtask

    task automatic t_reset_mid();
        w(ra(OFS_INPUT_BASE, 4), 32'h00000555);
        `CHK("busy mid", 1'b0, busy_pin)
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("busy reset", 1'b1, busy_pin)
        `CHK("code reset", 12'h000, codes[48 +: 12])
        rchk(OFS_STATUS, 32'h0, "flags reset");
        rchk(OFS_CONFIG, 32'h0, "enable reset");
    endtask

    // ****************************************
    // Run control
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_disabled();
        t_corr();
        t_prio();
        t_reset_mid();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule
